// File: logic/cbr_pkg.sv
// package for the clock buffer id and pll mode register bank
// assumes a byte-wide register port driven by a serial-bus engine on clk_i
package cbr_pkg;
    // register indices
    localparam logic [6:0] CBR_SPARE_A_IDX = 7'h03;
    localparam logic [6:0] CBR_SPARE_B_IDX = 7'h04;
    localparam logic [6:0] CBR_MAKER_REV_IDX = 7'h05;
    localparam logic [6:0] CBR_PART_ID_IDX = 7'h06;
    localparam logic [6:0] CBR_RB_LEN_IDX = 7'h07;
    localparam logic [6:0] CBR_PLL_OVR_IDX = 7'h12;
    // identity values, arbitrary neutral codes
    localparam logic [3:0] CBR_VENDOR_ID = 4'h5;
    localparam logic [3:0] CBR_REVISION = 4'h1;
    localparam logic [7:0] CBR_PART_ID = 8'h3c;
    // field layout
    localparam int CBR_RB_LEN_W = 5;
    localparam int CBR_SRC_SEL_BIT = 2;
    localparam logic [4:0] CBR_RB_LEN_RST = 5'h08;
    localparam logic [4:0] CBR_RB_LEN_MIN = 5'h01;
    localparam logic [7:0] CBR_ZERO_BYTE = 8'h00;
    // pll mode codes
    localparam logic [1:0] CBR_MODE_LBW = 2'h0;
    localparam logic [1:0] CBR_MODE_BYPASS = 2'h1;
    localparam logic [1:0] CBR_MODE_BAD = 2'h2;
    localparam logic [1:0] CBR_MODE_HBW = 2'h3;
    // strap pin levels as decoded by the tri-level receiver
    localparam logic [1:0] CBR_STRAP_LOW = 2'h0;
    localparam logic [1:0] CBR_STRAP_MID = 2'h1;
    localparam logic [1:0] CBR_STRAP_HIGH = 2'h3;
    // cycles the synchroniser needs before a strap capture
    localparam logic [1:0] CBR_STRAP_SETTLE = 2'h2;
    typedef enum logic [1:0] {CBR_ST_SETTLE, CBR_ST_DONE} cbr_strap_st_t;
endpackage

// File: logic/cbr_regs.sv
// register bytes 3..7 and 18 of the clock buffer control bank
// assumes a serial-bus engine on clk_i giving one-cycle read and write strobes
`timescale 1ns/1ps
module cbr_regs (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [6:0] reg_index_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic [1:0] pll_bandwidth_strap_i,
    output logic [4:0] block_read_len_o,
    output logic [1:0] pll_mode_o,
    output logic pll_mode_valid_o
);
    cbr_strap_if strap_bus ();

    logic [4:0] rb_len_reg, rb_len_next;
    logic pll_source_select_reg, pll_source_select_next;
    logic sw_pll_mode_bit0_reg, sw_pll_mode_bit0_next;
    logic sw_pll_mode_bit1_reg, sw_pll_mode_bit1_next;
    logic [1:0] mode_reg, mode_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg;
    logic [1:0] sw_mode;
    logic [4:0] len_out_reg, len_out_next;

    cbr_strap_latch u_strap (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .strap_level_i(pll_bandwidth_strap_i),
        .strap(strap_bus.latch)
    );

    assign sw_mode = {sw_pll_mode_bit1_reg, sw_pll_mode_bit0_reg};

    // register writes and applied pll mode
    always_comb begin
        rb_len_next = rb_len_reg;
        pll_source_select_next = pll_source_select_reg;
        sw_pll_mode_bit0_next = sw_pll_mode_bit0_reg;
        sw_pll_mode_bit1_next = sw_pll_mode_bit1_reg;
        if (reg_wr_i) begin
            case (reg_index_i)
                cbr_pkg::CBR_RB_LEN_IDX: rb_len_next = reg_wdata_i[cbr_pkg::CBR_RB_LEN_W-1:0];
                cbr_pkg::CBR_PLL_OVR_IDX: begin
                    pll_source_select_next = reg_wdata_i[cbr_pkg::CBR_SRC_SEL_BIT];
                    sw_pll_mode_bit1_next = reg_wdata_i[1];
                    sw_pll_mode_bit0_next = reg_wdata_i[0];
                end
                default: rb_len_next = rb_len_reg; // ids and spares ignore writes
            endcase
        end
        mode_next = mode_reg;
        if (pll_source_select_reg) begin
            if (sw_mode != cbr_pkg::CBR_MODE_BAD) begin
                mode_next = sw_mode; // codes match pll encoding
            end
        end else if (strap_bus.valid) begin
            mode_next = strap_bus.mode;
        end
        if (rb_len_reg == 5'h00) begin
            len_out_next = cbr_pkg::CBR_RB_LEN_MIN;
        end else begin
            len_out_next = rb_len_reg;
        end
    end

    // read mux
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd_i) begin
            case (reg_index_i)
                cbr_pkg::CBR_SPARE_A_IDX: rdata_next = cbr_pkg::CBR_ZERO_BYTE;
                cbr_pkg::CBR_SPARE_B_IDX: rdata_next = cbr_pkg::CBR_ZERO_BYTE;
                cbr_pkg::CBR_MAKER_REV_IDX:
                    rdata_next = {cbr_pkg::CBR_REVISION, cbr_pkg::CBR_VENDOR_ID};
                cbr_pkg::CBR_PART_ID_IDX: rdata_next = cbr_pkg::CBR_PART_ID;
                cbr_pkg::CBR_RB_LEN_IDX: rdata_next = {3'h0, rb_len_reg};
                cbr_pkg::CBR_PLL_OVR_IDX: rdata_next = {5'h00, pll_source_select_reg,
                    sw_pll_mode_bit1_reg, sw_pll_mode_bit0_reg};
                default: rdata_next = cbr_pkg::CBR_ZERO_BYTE; // unmapped reads zero
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rb_len_reg <= cbr_pkg::CBR_RB_LEN_RST;
            len_out_reg <= cbr_pkg::CBR_RB_LEN_RST;
            pll_source_select_reg <= 1'b0;
            sw_pll_mode_bit0_reg <= 1'b0;
            sw_pll_mode_bit1_reg <= 1'b0;
            mode_reg <= cbr_pkg::CBR_MODE_LBW;
            rdata_reg <= cbr_pkg::CBR_ZERO_BYTE;
            rvalid_reg <= 1'b0;
        end else begin
            rb_len_reg <= rb_len_next;
            len_out_reg <= len_out_next;
            pll_source_select_reg <= pll_source_select_next;
            sw_pll_mode_bit0_reg <= sw_pll_mode_bit0_next;
            sw_pll_mode_bit1_reg <= sw_pll_mode_bit1_next;
            mode_reg <= mode_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= reg_rd_i;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign reg_rvalid_o = rvalid_reg;
    assign block_read_len_o = len_out_reg;
    assign pll_mode_o = mode_reg;
    assign pll_mode_valid_o = strap_bus.valid;
endmodule

// File: logic/cbr_strap_if.sv
// carries the latched strap mode from the strap latch to the register bank
// assumes both ends on clk_i
`timescale 1ns/1ps
interface cbr_strap_if;
    logic [1:0] mode;
    logic valid;
    modport latch (output mode, output valid);
    modport bank (input mode, input valid);
endinterface

// File: logic/cbr_strap_latch.sv
// synchronises the tri-level bandwidth strap and latches it once after reset
// assumes the strap pin is asynchronous and stable around power-up
`timescale 1ns/1ps
module cbr_strap_latch (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [1:0] strap_level_i,
    cbr_strap_if.latch strap
);
    logic [1:0] sync1_reg, sync2_reg;
    logic [1:0] cnt_reg, cnt_next;
    logic [1:0] mode_reg, mode_next;
    cbr_pkg::cbr_strap_st_t st_reg, st_next;

    // two-stage synchroniser, first stage read only by the second
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
        end else begin
            sync1_reg <= strap_level_i;
            sync2_reg <= sync1_reg;
        end
    end

    // settle then capture once
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        mode_next = mode_reg;
        case (st_reg)
            cbr_pkg::CBR_ST_SETTLE: begin
                if (cnt_reg == cbr_pkg::CBR_STRAP_SETTLE) begin
                    st_next = cbr_pkg::CBR_ST_DONE;
                    case (sync2_reg)
                        cbr_pkg::CBR_STRAP_HIGH: mode_next = cbr_pkg::CBR_MODE_HBW;
                        cbr_pkg::CBR_STRAP_LOW: mode_next = cbr_pkg::CBR_MODE_LBW;
                        default: mode_next = cbr_pkg::CBR_MODE_BYPASS; // middle
                    endcase
                end else begin
                    cnt_next = cnt_reg + 2'h1;
                end
            end
            cbr_pkg::CBR_ST_DONE: st_next = cbr_pkg::CBR_ST_DONE;
            default: st_next = cbr_pkg::CBR_ST_SETTLE;
        endcase
    end

    // latch state
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_reg <= cbr_pkg::CBR_ST_SETTLE;
            cnt_reg <= 2'h0;
            mode_reg <= cbr_pkg::CBR_MODE_LBW;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            mode_reg <= mode_next;
        end
    end

    assign strap.mode = mode_reg;
    assign strap.valid = (st_reg == cbr_pkg::CBR_ST_DONE);
endmodule

// File: tb/cbr_host_model.sv
// serial-bus host model issuing single-byte reads and writes
// assumes the bank answers a read one cycle after the strobe
`timescale 1ns/1ps
module cbr_host_model (
    input wire logic clk_i,
    input wire logic reg_rvalid_i,
    input wire logic [7:0] reg_rdata_i,
    output logic [6:0] reg_index_o = 7'h7f,
    output logic [7:0] reg_wdata_o = 8'h00,
    output logic reg_wr_o = 1'b0,
    output logic reg_rd_o = 1'b0
);
    // one-cycle write strobe, lines inverted once released
    task automatic wr(input logic [6:0] i, input logic [7:0] d);
        @(posedge clk_i) #1;
        {reg_index_o, reg_wdata_o, reg_wr_o} = {i, d, 1'b1};
        @(posedge clk_i) #1;
        {reg_index_o, reg_wdata_o, reg_wr_o} = {~i, ~d, 1'b0};
    endtask
    // one-cycle read strobe, bounded wait for the answer
    task automatic rd(input logic [6:0] i, output logic [7:0] d, output logic ok);
        @(posedge clk_i) #1;
        {reg_index_o, reg_rd_o} = {i, 1'b1};
        @(posedge clk_i) #1;
        {reg_index_o, reg_rd_o} = {~i, 1'b0};
        for (int n = 0; n < 3 && reg_rvalid_i !== 1'b1; n++) @(posedge clk_i) #1;
        {d, ok} = {reg_rdata_i, reg_rvalid_i === 1'b1};
    endtask
endmodule

// File: tb/cbr_regs_monitor.sv
// checker for the clock buffer id and pll mode register bank
// assumes it sees only the ports of cbr_regs, bound below
`timescale 1ns/1ps
module cbr_regs_monitor (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [6:0] reg_index_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic [4:0] block_read_len_o,
    input wire logic [1:0] pll_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_spare; reg_rd_i && reg_index_i inside {7'h03, 7'h04} |=> reg_rdata_o == 8'h00; endproperty
    property p_maker; reg_rd_i && reg_index_i == 7'h05 |=> reg_rdata_o == {cbr_pkg::CBR_REVISION, cbr_pkg::CBR_VENDOR_ID}; endproperty
    property p_part; reg_rd_i && reg_index_i == 7'h06 |=> reg_rvalid_o && reg_rdata_o == cbr_pkg::CBR_PART_ID; endproperty
    property p_len; reg_wr_i && reg_index_i == 7'h07 && reg_wdata_i[4:0] != 5'h00 |-> ##2 block_read_len_o == $past(reg_wdata_i[4:0], 2); endproperty
    property p_len_top; reg_rd_i && reg_index_i == 7'h07 |=> reg_rdata_o[7:5] == 3'h0; endproperty
    property p_len_rst; $fell(sys_rst_i) |-> block_read_len_o == 5'h08; endproperty
    property p_ovr; reg_wr_i && reg_index_i == 7'h12 && reg_wdata_i[2] && reg_wdata_i[1:0] != 2'h2 |-> ##2 pll_mode_o == $past(reg_wdata_i[1:0], 2); endproperty
    property p_len_nz; block_read_len_o != 5'h00; endproperty
    property p_keep; pll_mode_o != cbr_pkg::CBR_MODE_BAD; endproperty
    property p_quiet; !reg_rd_i |=> !reg_rvalid_o; endproperty
    a_spare: assert property (p_spare) else $error("spare byte not zero");
    a_maker: assert property (p_maker) else $error("maker byte wrong");
    a_part: assert property (p_part) else $error("part byte wrong");
    a_len: assert property (p_len) else $error("count not applied");
    a_len_top: assert property (p_len_top) else $error("count top bits set");
    a_len_rst: assert property (p_len_rst) else $error("count reset wrong");
    a_ovr: assert property (p_ovr) else $error("override not applied");
    a_len_nz: assert property (p_len_nz) else $error("zero block count");
    a_keep: assert property (p_keep) else $error("undefined mode applied");
    a_quiet: assert property (p_quiet) else $error("unasked read valid");
    c_ovr: cover property (reg_wr_i && reg_index_i == 7'h12 && reg_wdata_i[2]);
    c_len: cover property (reg_wr_i && reg_index_i == 7'h07);
    c_rst: cover property ($fell(sys_rst_i));
endmodule
bind cbr_regs cbr_regs_monitor u_cbr_regs_monitor (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_index_i(reg_index_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .block_read_len_o(block_read_len_o), .pll_mode_o(pll_mode_o));

// File: tb/cbr_regs_tb_top.sv
// self-checking bench for the id and pll mode register bank
// assumes the host model drives the register port, the bench drives the strap
`timescale 1ns/1ps
module cbr_regs_tb_top;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [1:0] strap = cbr_pkg::CBR_STRAP_HIGH;
    logic [6:0] idx;
    logic [7:0] wd;
    logic [7:0] rdata;
    logic wr;
    logic rd;
    logic rvalid;
    logic mvalid;
    logic [4:0] len;
    logic [1:0] mode;
    int n_errors = 0;
    int n_compared = 0;
    // free-running 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    cbr_regs u_cbr_regs (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_index_i(idx),
        .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .pll_bandwidth_strap_i(strap), .block_read_len_o(len),
        .pll_mode_o(mode), .pll_mode_valid_o(mvalid));
    cbr_host_model u_cbr_host_model (.clk_i(clk_i), .reg_rvalid_i(rvalid),
        .reg_rdata_i(rdata), .reg_index_o(idx), .reg_wdata_o(wd), .reg_wr_o(wr),
        .reg_rd_o(rd));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic do_reset(input logic [1:0] s);
        {strap, sys_rst_i} = {s, 1'b1};
        repeat (12) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (6) @(posedge clk_i) #1;
    endtask
    task automatic rd_chk(input logic [6:0] i, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        u_cbr_host_model.rd(i, d, ok);
        chk("rvalid", {7'h00, ok}, 8'h01);
        chk($sformatf("reg %h", i), d, e);
        // a read that never answered ends the run
        if (ok !== 1'b1) give_verdict();
    endtask
    task automatic t_reset_vals;
        rd_chk(7'h03, 8'h00);
        rd_chk(7'h04, 8'h00);
        rd_chk(7'h05, {cbr_pkg::CBR_REVISION, cbr_pkg::CBR_VENDOR_ID});
        rd_chk(7'h06, cbr_pkg::CBR_PART_ID);
        rd_chk(7'h07, 8'h08);
        rd_chk(7'h12, 8'h00);
        rd_chk(7'h20, 8'h00);
        chk("len", {3'h0, len}, 8'h08);
        chk("mode", {6'h00, mode}, {6'h00, cbr_pkg::CBR_MODE_HBW});
    endtask
    task automatic t_ro;
        for (int i = 3; i < 7; i++) u_cbr_host_model.wr(7'(i), 8'hff);
        t_reset_vals();
    endtask
    task automatic t_count;
        logic [7:0] w[4] = '{8'hff, 8'h01, 8'h00, 8'h08};
        logic [7:0] e[4] = '{8'h1f, 8'h01, 8'h01, 8'h08};
        for (int k = 0; k < 4; k++) begin
            u_cbr_host_model.wr(7'h07, w[k]);
            @(posedge clk_i) #1;
            chk("len", {3'h0, len}, e[k]);
            rd_chk(7'h07, w[k] & 8'h1f);
        end
    endtask
    task automatic t_strap;
        logic [1:0] lv[3] = '{cbr_pkg::CBR_STRAP_LOW, cbr_pkg::CBR_STRAP_MID, 2'h3};
        logic [1:0] md[3] = '{cbr_pkg::CBR_MODE_LBW, cbr_pkg::CBR_MODE_BYPASS, 2'h3};
        for (int k = 0; k < 3; k++) begin
            do_reset(lv[k]);
            chk("mvalid", {7'h00, mvalid}, 8'h01);
            chk("mode", {6'h00, mode}, {6'h00, md[k]});
        end
    endtask
    task automatic t_override;
        // last step leaves bypass so that the restored strap mode shows as a change
        logic [7:0] w[8] = '{8'h04, 8'h05, 8'h07, 8'h06, 8'h05, 8'h06, 8'hfd, 8'h01};
        logic [1:0] e[8] = '{2'h0, 2'h1, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h3};
        for (int k = 0; k < 8; k++) begin
            u_cbr_host_model.wr(7'h12, w[k]);
            @(posedge clk_i) #1;
            chk("mode", {6'h00, mode}, {6'h00, e[k]});
            rd_chk(7'h12, w[k] & 8'h07);
        end
    endtask
    // main sequence, then a watchdog that ends a hung run
    initial begin
        do_reset(cbr_pkg::CBR_STRAP_HIGH);
        t_reset_vals();
        t_ro();
        t_count();
        t_strap();
        t_override();
        give_verdict();
    end
    initial begin
        #500000;
        n_errors++;
        give_verdict();
    end
endmodule
